// *** core/tpc_pkg.sv ***
/*
  Constants for the thermal printer controller: task tick, phase
  patterns, font geometry and parallel-port timing.
  Assumes a 125 MHz core clock.
*/
package tpc_pkg;
  localparam int          CLK_HZ        = 125000000;
  localparam int          TICK_US       = 100;
  localparam int          TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
  localparam int          ACK_NS        = 1000;
  localparam int          ACK_CYCLES    = (ACK_NS * 125 + 999) / 1000;
  localparam logic [3:0]  PHASE_0       = 4'hc;
  localparam logic [3:0]  PHASE_1       = 4'h6;
  localparam logic [3:0]  PHASE_2       = 4'h3;
  localparam logic [3:0]  PHASE_3       = 4'h9;
  localparam int          FONT_COLS     = 5;
  localparam int          CELL_STEPS    = FONT_COLS + 1;
  localparam logic [7:0]  STEP_TICKS_RST = 8'h28;
  localparam logic [7:0]  DOT_TICKS_RST  = 8'h0e;
  localparam logic [7:0]  DOT_MAX_RST    = 8'h19;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_WIDTH    = 8;

  typedef enum logic [2:0] {
    ST_CLEAR  = 3'b000,
    ST_SEEK   = 3'b001,
    ST_EDGE   = 3'b010,
    ST_IDLE   = 3'b011,
    ST_STEP   = 3'b100,
    ST_SETTLE = 3'b101,
    ST_DOTS   = 3'b110
  } tpc_state_e;
endpackage

// *** core/tpc_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Write side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_reg != rd_reg;
  assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** core/tpc_top.sv ***
/*
  Thermal printer controller: homing, head and paper steppers, dot
  pulses, serial/parallel byte intake through a FIFO, font lookup.
  Assumes synchronous inputs, a debounced home line and an external
  watchdog on the dot supply.
*/
`timescale 1ns/10ps
`default_nettype none
module tpc_top
  import tpc_pkg::*;
#(
  parameter int FONT_CHARS = 128
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Configuration and status levels
  input  wire logic [7:0] step_ticks_i,
  input  wire logic [7:0] dot_ticks_i,
  input  wire logic [7:0] dot_max_i,
  input  wire logic       online_i,
  input  wire logic       paper_out_i,
  input  wire logic       fault_i,
  input  wire logic       power_good_i,
  // Mechanics
  input  wire logic       home_n_i,
  output logic [3:0]      head_phase_o,
  output logic [3:0]      paper_phase_o,
  output logic [7:0]      dots_o,
  output logic            dot_supply_en_o,
  output logic            home_edge_irq_o,
  output logic            homed_o,
  // Serial receive and transmit
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output logic            serial_not_ready_o,
  output logic            tx_o,
  // Parallel port
  input  wire logic [7:0] host_data_i,
  input  wire logic       host_byte_strobe_n_i,
  input  wire logic       auto_linefeed_n_i,
  input  wire logic       host_init_n_i,
  input  wire logic       host_select_in_n_i,
  output logic            byte_taken_ack_n_o,
  output logic            printer_busy_o,
  output logic            paper_empty_o,
  output logic            printer_selected_o,
  output logic            machine_error_n_o
);
  import tpc_pkg::*;

  // ----------------------------------------------------------------
  // Task tick
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_reg;
  logic        tick;
  assign tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Byte intake
  // ----------------------------------------------------------------
  logic       strobe_d_reg;
  logic       par_hold_reg;
  logic [7:0] par_byte_reg;
  logic       fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] ack_cnt_reg;
  logic       strobe_fall;
  logic       offline;

  assign offline     = !online_i || host_select_in_n_i == 1'b1;
  assign strobe_fall = strobe_d_reg && !host_byte_strobe_n_i;
  // Parallel byte has priority; a serial byte in the same cycle is dropped
  assign fifo_in_valid = par_hold_reg || rx_valid_i;
  assign fifo_in_data  = par_hold_reg ? par_byte_reg : rx_data_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_d_reg <= 1'b1;
      par_hold_reg <= 1'b0;
      par_byte_reg <= 8'h00;
    end else begin
      strobe_d_reg <= host_byte_strobe_n_i;
      if (strobe_fall && !par_hold_reg) begin
        par_hold_reg <= 1'b1;
        par_byte_reg <= host_data_i;
      end else if (par_hold_reg && fifo_in_ready) begin
        par_hold_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_cnt_reg <= 8'h00;
    end else if (par_hold_reg && fifo_in_ready) begin
      ack_cnt_reg <= 8'(ACK_CYCLES);
    end else if (ack_cnt_reg != 8'h00) begin
      ack_cnt_reg <= ack_cnt_reg - 8'h01;
    end
  end

  tpc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Host status
  // ----------------------------------------------------------------
  assign tx_o               = 1'b1;
  assign serial_not_ready_o = !fifo_in_ready || par_hold_reg
                              || offline;
  assign printer_busy_o     = offline || fault_i || paper_out_i
                              || par_hold_reg || !fifo_in_ready
                              || ack_cnt_reg != 8'h00
                              || !host_init_n_i;
  assign byte_taken_ack_n_o = ack_cnt_reg == 8'h00;
  assign printer_selected_o = power_good_i && !offline;
  assign paper_empty_o      = paper_out_i;
  assign machine_error_n_o  = !fault_i;

  // ----------------------------------------------------------------
  // Home input
  // ----------------------------------------------------------------
  logic home_d_reg;
  logic home_fall;
  assign home_fall = home_d_reg && !home_n_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      home_d_reg      <= home_n_i;
      home_edge_irq_o <= 1'b0;
    end else begin
      home_d_reg      <= home_n_i;
      home_edge_irq_o <= home_fall;
    end
  end

  // ----------------------------------------------------------------
  // Font ROM: column bitmaps, bit 0 is dot one
  // ----------------------------------------------------------------
  logic [7:0] font_rom [FONT_CHARS*FONT_COLS];
  logic [6:0] char_reg;
  logic [2:0] col_reg;
  logic [9:0] font_addr;
  always_comb begin
    for (int i = 0; i < FONT_CHARS*FONT_COLS; i++) begin
      font_rom[i] = 8'h00;
    end
    // Character two
    font_rom[50*FONT_COLS+0] = 8'h82;
    font_rom[50*FONT_COLS+1] = 8'hc1;
    font_rom[50*FONT_COLS+2] = 8'ha1;
    font_rom[50*FONT_COLS+3] = 8'h91;
    font_rom[50*FONT_COLS+4] = 8'h8e;
  end
  // Code times columns plus col_reg minus one (step 0 is blank)
  assign font_addr = 10'(char_reg * FONT_COLS) + 10'(col_reg - 3'd1);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  tpc_state_e state_reg;
  logic [7:0] tick_cnt2_reg;
  logic [1:0] head_idx_reg;
  logic [1:0] paper_idx_reg;
  logic       head_dir_reg;
  logic [7:0] col_bits_reg;
  logic       homed_reg;

  assign fifo_out_ready = state_reg == ST_IDLE;
  assign homed_o        = homed_reg;

  function automatic logic [3:0] phase_of(input logic [1:0] idx);
    unique case (idx)
      2'd0: phase_of = PHASE_0;
      2'd1: phase_of = PHASE_1;
      2'd2: phase_of = PHASE_2;
      2'd3: phase_of = PHASE_3;
    endcase
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= ST_CLEAR;
      tick_cnt2_reg <= 8'h00;
      head_idx_reg  <= 2'd0;
      paper_idx_reg <= 2'd0;
      head_dir_reg  <= 1'b0;
      char_reg      <= 7'h00;
      col_reg       <= 3'd0;
      col_bits_reg  <= 8'h00;
      homed_reg     <= 1'b0;
      head_phase_o  <= 4'h0;
      paper_phase_o <= 4'h0;
      dots_o        <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_CLEAR: begin
          dots_o    <= 8'h00;
          // Poll level; if at home, back off right first
          head_dir_reg <= !home_n_i;
          state_reg <= ST_SEEK;
        end
        ST_SEEK: begin
          if (home_fall && head_dir_reg == 1'b0) begin
            homed_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (head_dir_reg && home_n_i) begin
            head_dir_reg <= 1'b0;
          end else if (tick) begin
            if (tick_cnt2_reg + 8'h01 >= step_ticks_i) begin
              tick_cnt2_reg <= 8'h00;
              head_idx_reg  <= head_dir_reg ? head_idx_reg + 2'd1
                                            : head_idx_reg - 2'd1;
              head_phase_o  <= phase_of(head_dir_reg
                ? head_idx_reg + 2'd1 : head_idx_reg - 2'd1);
            end else begin
              tick_cnt2_reg <= tick_cnt2_reg + 8'h01;
            end
          end
        end
        ST_EDGE: begin
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          tick_cnt2_reg <= 8'h00;
          if (fifo_out_valid) begin
            if (fifo_out_data == 8'h0a) begin
              paper_idx_reg <= paper_idx_reg + 2'd1;
              paper_phase_o <= phase_of(paper_idx_reg + 2'd1);
              state_reg     <= ST_CLEAR;
            end else begin
              char_reg  <= fifo_out_data[6:0];
              col_reg   <= 3'd0;
              state_reg <= ST_STEP;
            end
          end
        end
        ST_STEP: begin
          dots_o        <= 8'h00;
          head_idx_reg  <= head_idx_reg + 2'd1;
          head_phase_o  <= phase_of(head_idx_reg + 2'd1);
          col_bits_reg  <= (col_reg == 3'd0) ? 8'h00
                           : font_rom[font_addr];
          tick_cnt2_reg <= 8'h00;
          state_reg     <= ST_SETTLE;
        end
        ST_SETTLE: begin
          dots_o    <= col_bits_reg;
          state_reg <= ST_DOTS;
        end
        ST_DOTS: begin
          if (tick) begin
            tick_cnt2_reg <= tick_cnt2_reg + 8'h01;
            if (tick_cnt2_reg + 8'h01 >= dot_ticks_i
                || tick_cnt2_reg + 8'h01 >= dot_max_i) begin
              dots_o <= 8'h00;
            end
            if (tick_cnt2_reg + 8'h01 >= step_ticks_i
                && tick_cnt2_reg + 8'h01 >= dot_ticks_i) begin
              dots_o <= 8'h00;
              if (col_reg == 3'(CELL_STEPS - 1)) begin
                state_reg <= ST_IDLE;
              end else begin
                col_reg   <= col_reg + 3'd1;
                state_reg <= ST_STEP;
              end
            end
          end
        end
        default: state_reg <= ST_CLEAR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Dot on-time guard
  // ----------------------------------------------------------------
  logic [8:0] dot_on_ticks_reg;
  logic       dot_trip_reg;

  // Ticks seen with any dot lit; cleared when all dots are off
  always_ff @(posedge clk_i) begin
    if (rst_i || dots_o == 8'h00) begin
      dot_on_ticks_reg <= 9'h000;
    end else if (tick) begin
      dot_on_ticks_reg <= dot_on_ticks_reg + 9'h001;
    end
  end

  // Latched trip: a pulse past the limit cuts the dot supply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dot_trip_reg <= 1'b0;
    end else if (dot_on_ticks_reg > {1'b0, dot_max_i}) begin
      dot_trip_reg <= 1'b1;
    end
  end

  // Watchdog path: supply only while healthy and homed
  assign dot_supply_en_o = homed_reg && !fault_i && power_good_i
                           && !dot_trip_reg;
endmodule
`default_nettype wire

// *** testbench/tpc_top_monitor.sv ***
/* Port checker for tpc_top.
   Assumes one clock domain and a bind onto every tpc_top. */
`timescale 1ns/10ps
`default_nettype none
module tpc_monitor
  import tpc_pkg::*;
(
  // Clock, reset, levels
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       online_i,
  input wire logic       paper_out_i,
  input wire logic       fault_i,
  input wire logic       power_good_i,
  input wire logic       home_n_i,
  // Watched outputs
  input wire logic [3:0] head_phase_o,
  input wire logic [3:0] paper_phase_o,
  input wire logic [7:0] dots_o,
  input wire logic       home_edge_irq_o,
  input wire logic       homed_o,
  input wire logic       tx_o,
  input wire logic       byte_taken_ack_n_o,
  input wire logic       printer_busy_o,
  input wire logic       paper_empty_o,
  input wire logic       printer_selected_o,
  input wire logic       machine_error_n_o
);
  logic [7:0] ack_cnt_reg;
  logic [3:0] ph_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || byte_taken_ack_n_o) ack_cnt_reg <= 8'h00;
    else ack_cnt_reg <= ack_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) ph_prev_reg <= 4'h0;
    else ph_prev_reg <= head_phase_o;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence move_s;
    head_phase_o != ph_prev_reg;
  endsequence
  sequence ack_end_s;
    $rose(byte_taken_ack_n_o);
  endsequence

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  reset_clear_a: assert property ($fell(rst_i) |->
    head_phase_o == 4'h0 && paper_phase_o == 4'h0 && dots_o == 8'h00)
    else $error("outputs not clear after reset");
  dots_after_step_a: assert property ($rose(dots_o != 8'h00) |->
    $past(head_phase_o) != $past(head_phase_o, 2))
    else $error("dots fired without a step just before");
  no_dots_move_a: assert property (move_s |-> dots_o == 8'h00)
    else $error("dots on during phase change");
  phase_order_a: assert property (move_s ##0 ph_prev_reg != 4'h0 |->
    head_phase_o == {ph_prev_reg[0], ph_prev_reg[3:1]} ||
    head_phase_o == {ph_prev_reg[2:0], ph_prev_reg[3]})
    else $error("head phase out of sequence");
  ack_width_a: assert property (ack_end_s |-> ack_cnt_reg == 8'(ACK_CYCLES))
    else $error("acknowledge width wrong");
  busy_level_a: assert property (
    !byte_taken_ack_n_o || !online_i || fault_i |-> printer_busy_o)
    else $error("busy low while not ready");
  status_level_a: assert property (paper_empty_o == paper_out_i &&
    machine_error_n_o == !fault_i && (!printer_selected_o || power_good_i))
    else $error("status outputs wrong");
  home_event_a: assert property ($fell(home_n_i) |-> ##[1:2] home_edge_irq_o)
    else $error("home event missing");
  print_homed_a: assert property (!homed_o |-> dots_o == 8'h00)
    else $error("dots before homing");
  tx_idle_a: assert property (tx_o)
    else $error("transmit line active");
endmodule

bind tpc_top tpc_monitor MON (.clk_i, .rst_i, .online_i, .paper_out_i,
  .fault_i, .power_good_i, .home_n_i, .head_phase_o, .paper_phase_o, .dots_o,
  .home_edge_irq_o, .homed_o, .tx_o, .byte_taken_ack_n_o, .printer_busy_o,
  .paper_empty_o, .printer_selected_o, .machine_error_n_o);
`default_nettype wire

// *** testbench/tpc_host_model.sv ***
/* Host model: serial bytes and strobed parallel bytes.
   Assumes it is called from the bench at falling clock edges. */
`timescale 1ns/10ps
`default_nettype none
module tpc_host_model (
  // Clock
  input  wire logic       clk_i,
  // Serial side
  input  wire logic       serial_not_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  // Parallel side
  output logic [7:0]      host_data_o,
  output logic            host_byte_strobe_n_o,
  output logic            auto_linefeed_n_o,
  output logic            host_init_n_o,
  output logic            host_select_in_n_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    host_data_o = 8'hff;
    host_byte_strobe_n_o = 1'b1;
    auto_linefeed_n_o = 1'b1;
    host_init_n_o = 1'b1;
    host_select_in_n_o = 1'b0;
  end

  task automatic set_select(input logic sel);
    host_select_in_n_o = sel;
  endtask

  task automatic send_ser(input logic [7:0] b);
    int n;
    n = 0;
    while (serial_not_ready_i !== 1'b0 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    rx_data_o = b;
    rx_valid_o = 1'b1;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~b;
  endtask

  task automatic send_par(input logic [7:0] b);
    host_data_o = b;
    @(negedge clk_i);
    host_byte_strobe_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    host_byte_strobe_n_o = 1'b1;
    @(negedge clk_i);
    host_data_o = 8'hff;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_thermal_printer_controller.sv ***
/* Self-checking bench for tpc_top with a host model.
   Assumes tpc_pkg, tpc_top, tpc_fifo and the host model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module test_thermal_printer_controller;
  import tpc_pkg::*;
  localparam int T = TICK_CYCLES;
  logic clk_i = 1'b0;
  logic rst_i, online_i, paper_out_i, fault_i, power_good_i, home_n_i;
  logic rx_valid_i, host_byte_strobe_n_i, auto_linefeed_n_i;
  logic host_init_n_i, host_select_in_n_i, saw_ack;
  logic [7:0] step_ticks_i, dot_ticks_i, dot_max_i, host_data_i, rx_data_i;
  logic [3:0] head_phase_o, paper_phase_o;
  logic [7:0] dots_o;
  logic dot_supply_en_o, home_edge_irq_o, homed_o, serial_not_ready_o, tx_o;
  logic byte_taken_ack_n_o, printer_busy_o, paper_empty_o;
  logic printer_selected_o, machine_error_n_o;
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] fifo_q[$];
  int ack_run = 0;
  int ack_len = 0;

  always #4 clk_i = ~clk_i;

  // Width of the last completed acknowledge pulse, in cycles
  always @(negedge clk_i) begin
    if (byte_taken_ack_n_o === 1'b0) begin
      ack_run <= ack_run + 1;
    end else if (ack_run != 0) begin
      ack_len <= ack_run;
      ack_run <= 0;
    end
  end

  tpc_top DUT (.clk_i, .rst_i, .step_ticks_i, .dot_ticks_i, .dot_max_i,
    .online_i, .paper_out_i, .fault_i, .power_good_i, .home_n_i,
    .head_phase_o, .paper_phase_o, .dots_o, .dot_supply_en_o,
    .home_edge_irq_o, .homed_o, .rx_valid_i, .rx_data_i, .serial_not_ready_o,
    .tx_o, .host_data_i, .host_byte_strobe_n_i, .auto_linefeed_n_i,
    .host_init_n_i, .host_select_in_n_i, .byte_taken_ack_n_o, .printer_busy_o,
    .paper_empty_o, .printer_selected_o, .machine_error_n_o);

  tpc_host_model HOST (.clk_i, .serial_not_ready_i(serial_not_ready_o),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .host_data_o(host_data_i),
    .host_byte_strobe_n_o(host_byte_strobe_n_i),
    .auto_linefeed_n_o(auto_linefeed_n_i), .host_init_n_o(host_init_n_i),
    .host_select_in_n_o(host_select_in_n_i));

  task automatic check_val(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic check_span(input string nm, input int lo, hi, g);
    cmp_count++;
    if (g < lo || g > hi) begin
      errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Cycles from one head step to the next, with dot activity seen
  task automatic next_step(output int len, on, output logic [7:0] seen);
    logic [3:0] ph;
    ph = head_phase_o;
    len = 0;
    on = 0;
    seen = 8'h00;
    do begin
      @(negedge clk_i);
      len++;
      if (dots_o !== 8'h00) on++;
      seen = seen | dots_o;
      if (byte_taken_ack_n_o === 1'b0) saw_ack = 1'b1;
    end while (head_phase_o === ph && len < 3 * T);
  endtask

  initial begin
    repeat (5 * T) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  initial begin
    int len, on;
    logic [7:0] b, seen;
    logic off, sel;
    rst_i = 1'b1;
    {step_ticks_i, dot_ticks_i, dot_max_i} = 24'h010201;
    {online_i, paper_out_i, fault_i, power_good_i, home_n_i} = 5'h03;
    saw_ack = 1'b0;
    void'($urandom(59296));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 12; i++) begin
      {online_i, paper_out_i, fault_i, power_good_i, sel} = 5'($urandom);
      HOST.set_select(sel);
      @(negedge clk_i);
      off = !online_i || sel;
      if (off || fault_i) check_val("busy", 8'h01, 8'(printer_busy_o));
      check_val("paper", 8'(paper_out_i), 8'(paper_empty_o));
      check_val("error", 8'(!fault_i), 8'(machine_error_n_o));
      check_val("select", 8'(power_good_i && !off), 8'(printer_selected_o));
    end
    {online_i, paper_out_i, fault_i, power_good_i} = 4'h9;
    HOST.set_select(1'b0);
    @(negedge clk_i);
    check_val("idle busy", 8'h00, 8'(printer_busy_o));
    HOST.send_par(8'h32);
    fifo_q.push_back(8'h32);
    repeat (20) if (byte_taken_ack_n_o !== 1'b0) @(negedge clk_i);
    len = 0;
    while (byte_taken_ack_n_o === 1'b0 && len < 300) begin
      @(negedge clk_i);
      len++;
    end
    @(negedge clk_i);
    check_val("ack width", 8'(ACK_CYCLES), 8'(ack_len));
    check_val("busy after", 8'h00, 8'(printer_busy_o));
    while (fifo_q.size() < FIFO_DEPTH) begin
      b = 8'h30 + 8'($urandom % 64);
      HOST.send_ser(b);
      fifo_q.push_back(b);
      @(negedge clk_i);
      check_val("not ready", 8'(fifo_q.size() >= FIFO_DEPTH), 8'(serial_not_ready_o));
    end
    HOST.send_par(8'h32);
    repeat (60) @(negedge clk_i);
    check_val("stalled ack", 8'h01, 8'(byte_taken_ack_n_o));
    check_val("stalled busy", 8'h01, 8'(printer_busy_o));
    check_val("supply early", 8'h00, 8'(dot_supply_en_o));
    home_n_i = 1'b0;
    len = 0;
    while (homed_o !== 1'b1 && len < 30000) begin
      @(negedge clk_i);
      len++;
    end
    check_val("homed", 8'h01, 8'(homed_o));
    next_step(len, on, seen);
    next_step(len, on, seen);
    check_val("blank column", 8'h00, seen);
    void'(fifo_q.pop_front());
    fifo_q.push_back(8'h32);
    check_val("ack on pop", 8'h01, 8'(saw_ack));
    check_val("still full", 8'(fifo_q.size() >= FIFO_DEPTH), 8'(serial_not_ready_o));
    next_step(len, on, seen);
    check_val("column dots", 8'h82, seen);
    check_span("step period", 2 * T - 1, 2 * T + 1, len);
    check_span("dot width", T - 2, T, on);
    check_val("supply on", 8'h01, 8'(dot_supply_en_o));
    check_val("paper phase", 8'h00, 8'(paper_phase_o));
    print_verdict();
  end
endmodule
`default_nettype wire
